// [hwk_fabric_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hwk_fabric_model
  import hwk_pkg::*;
(
  input  wire logic                   pclk,
  output logic                        rx_frame_end,
  output logic                        rx_frame_ok,
  output logic [hwk_pkg::DA_W-1:0]    rx_dest_addr,
  output logic                        rx_magic_seen,
  output logic                        rx_filter_hit
);
  import hwk_pkg::*;

  initial begin
    rx_frame_end  = 1'b0;
    rx_frame_ok   = 1'b0;
    rx_dest_addr  = '0;
    rx_magic_seen = 1'b0;
    rx_filter_hit = 1'b0;
  end

  // Qualifiers mean nothing off the end pulse, so they are scrambled there
  task automatic send(input logic [DA_W-1:0] da, input logic ok,
                      input logic magic, input logic hit);
    @(posedge pclk);
    rx_frame_end  <= 1'b1;
    rx_frame_ok   <= ok;
    rx_dest_addr  <= da;
    rx_magic_seen <= magic;
    rx_filter_hit <= hit;
    @(posedge pclk);
    rx_frame_end  <= 1'b0;
    rx_frame_ok   <= ~ok;
    rx_dest_addr  <= ~da;
    rx_magic_seen <= ~magic;
    rx_filter_hit <= ~hit;
  endtask
endmodule
`default_nettype wire

// [hwk_frame_qual.sv]
`timescale 1ns/1ps
`default_nettype none
module hwk_frame_qual
  import hwk_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            rx_frame_end,
  input  wire logic            rx_frame_ok,
  input  wire logic [DA_W-1:0] rx_dest_addr,
  input  wire logic            rx_magic_seen,
  input  wire logic            rx_filter_hit,
  input  wire logic            global_unicast_wake_enable,
  input  wire logic            wake_frame_enable,
  input  wire logic            magic_packet_enable,
  output logic                 unicast_hit,
  output logic                 wake_frame_hit,
  output logic                 magic_hit
);
  logic frame_valid;

  // Only frames that ended without error may qualify
  assign frame_valid = rx_frame_end & rx_frame_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unicast_hit    <= 1'b0;
      wake_frame_hit <= 1'b0;
      magic_hit      <= 1'b0;
    end else begin
      unicast_hit    <= frame_valid & global_unicast_wake_enable
                        & ~rx_dest_addr[DA_GROUP_BIT];
      wake_frame_hit <= frame_valid & wake_frame_enable
                        & rx_filter_hit;
      magic_hit      <= frame_valid & magic_packet_enable
                        & rx_magic_seen;
    end
  end
endmodule
`default_nettype wire

// [hwk_pkg.sv]
`default_nettype none
package hwk_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DA_W   = 48;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_FILTER = 6'h0b;
  localparam logic [5:0] IDX_CSR    = 6'h0c;
  localparam logic [ADDR_W-1:0] ADDR_FILTER = {IDX_FILTER, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CSR    = {IDX_CSR, 2'b00};

  // Control/status field positions
  localparam int BIT_GUE  = 9;
  localparam int BIT_WAKE_FRAME_RECEIVED = 6;
  localparam int BIT_MPR  = 5;
  localparam int BIT_WAKE_FRAME_ENABLE = 2;
  localparam int BIT_MAGIC_PACKET_ENABLE = 1;
  localparam logic [DATA_W-1:0] CSR_DEFINED = 32'h0000_0266;
  localparam logic CSR_BIT_RESET = 1'b0;

  // Wake-up frame filter store
  localparam int FILTER_WORDS = 8;
  localparam int PTR_W        = 3;
  localparam logic [PTR_W-1:0] PTR_FIRST = 3'h0;
  localparam logic [PTR_W-1:0] PTR_LAST  = 3'h7;
  localparam logic [DATA_W-1:0] FILTER_RESET = 32'h0000_0000;

  // Group bit of the destination address, first octet on the wire
  localparam int DA_GROUP_BIT = 0;

  // APB slave phase
  typedef enum logic [0:0] {
    HWK_IDLE,
    HWK_ANSWER
  } hwk_apb_e;

  // Decode outcome of a bus address
  typedef enum logic [1:0] {
    HWK_SEL_NONE,
    HWK_SEL_FILTER,
    HWK_SEL_CSR
  } hwk_sel_e;
endpackage
`default_nettype wire

// [hwk_wakeup_ctrl.sv]
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module hwk_wakeup_ctrl
  import hwk_pkg::*;
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [hwk_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [hwk_pkg::DATA_W-1:0]   pwdata,
  output logic      [hwk_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         digital_reset,
  input  wire logic                         soft_reset,
  input  wire logic                         rx_frame_end,
  input  wire logic                         rx_frame_ok,
  input  wire logic [hwk_pkg::DA_W-1:0]     rx_dest_addr,
  input  wire logic                         rx_magic_seen,
  input  wire logic                         rx_filter_hit,
  input  wire logic                         power_save,
  output logic [hwk_pkg::FILTER_WORDS*hwk_pkg::DATA_W-1:0] wakeup_frame_filter,
  output logic [hwk_pkg::PTR_W-1:0]         filter_write_ptr,
  output logic                              wake_event
);
  import hwk_pkg::*;

  hwk_apb_e           apb_state;
  logic               global_unicast_wake_enable;
  logic               wake_frame_received;
  logic               magic_packet_received;
  logic               wake_frame_enable;
  logic               magic_packet_enable;
  logic [DATA_W-1:0]  filter_entry_word [FILTER_WORDS];
  logic               unicast_hit;
  logic               wake_frame_hit;
  logic               magic_hit;
  logic               access;
  logic               commit;
  logic               wr_csr;
  logic               wr_filter;
  logic               local_reset;
  logic               clr_wake_frame_received;
  logic               clr_mpr;
  logic [DATA_W-1:0]  csr_view;
  logic [PTR_W-1:0]   next_ptr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic hwk_sel_e decode(input logic [ADDR_W-1:0] a);
    hwk_sel_e s;
    s = HWK_SEL_NONE;
    if (a == ADDR_FILTER) begin
      s = HWK_SEL_FILTER;
    end else if (a == ADDR_CSR) begin
      s = HWK_SEL_CSR;
    end
    return s;
  endfunction

  // One wait state: read data and error come from flops
  assign access    = psel & penable & (apb_state == HWK_IDLE);
  assign commit    = psel & penable & pready;
  assign wr_csr    = commit & pwrite & (decode(paddr) == HWK_SEL_CSR);
  assign wr_filter = commit & pwrite & (decode(paddr) == HWK_SEL_FILTER);
  assign local_reset = digital_reset | soft_reset;
  assign clr_wake_frame_received  = wr_csr & pwdata[BIT_WAKE_FRAME_RECEIVED];
  assign clr_mpr   = wr_csr & pwdata[BIT_MPR];

  always_comb begin
    csr_view = '0;
    csr_view[BIT_GUE]  = global_unicast_wake_enable;
    csr_view[BIT_WAKE_FRAME_RECEIVED] = wake_frame_received;
    csr_view[BIT_MPR]  = magic_packet_received;
    csr_view[BIT_WAKE_FRAME_ENABLE] = wake_frame_enable;
    csr_view[BIT_MAGIC_PACKET_ENABLE] = magic_packet_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= HWK_IDLE;
      pready    <= 1'b0;
    end else begin
      unique case (apb_state)
        HWK_IDLE: begin
          if (psel && penable) begin
            apb_state <= HWK_ANSWER;
            pready    <= 1'b1;
          end
        end
        HWK_ANSWER: begin
          apb_state <= HWK_IDLE;
          pready    <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (access) begin
      pslverr <= (decode(paddr) == HWK_SEL_NONE);
      // Filter is write-only and reads as zero
      if (!pwrite && decode(paddr) == HWK_SEL_CSR) begin
        prdata <= csr_view;
      end else begin
        prdata <= '0;
      end
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // Enables: plain read/write, reserved bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_unicast_wake_enable <= CSR_BIT_RESET;
      wake_frame_enable          <= CSR_BIT_RESET;
      magic_packet_enable        <= CSR_BIT_RESET;
    end else if (local_reset) begin
      global_unicast_wake_enable <= CSR_BIT_RESET;
      wake_frame_enable          <= CSR_BIT_RESET;
      magic_packet_enable        <= CSR_BIT_RESET;
    end else if (wr_csr) begin
      global_unicast_wake_enable <= pwdata[BIT_GUE];
      wake_frame_enable          <= pwdata[BIT_WAKE_FRAME_ENABLE];
      magic_packet_enable        <= pwdata[BIT_MAGIC_PACKET_ENABLE];
    end
  end

  // Sticky flags; a hit in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_frame_received   <= CSR_BIT_RESET;
      magic_packet_received <= CSR_BIT_RESET;
    end else if (local_reset) begin
      wake_frame_received   <= CSR_BIT_RESET;
      magic_packet_received <= CSR_BIT_RESET;
    end else begin
      wake_frame_received   <= (wake_frame_received & ~clr_wake_frame_received)
                               | wake_frame_hit;
      magic_packet_received <= (magic_packet_received & ~clr_mpr)
                               | magic_hit;
    end
  end

  assign next_ptr = (filter_write_ptr == PTR_LAST) ? PTR_FIRST
                    : filter_write_ptr + 3'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_write_ptr <= PTR_FIRST;
    end else if (local_reset) begin
      filter_write_ptr <= PTR_FIRST;
    end else if (wr_filter) begin
      filter_write_ptr <= next_ptr;
    end
  end

  // Filter contents survive digital and soft reset; only the pointer moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FILTER_WORDS; i++) begin
        filter_entry_word[i] <= FILTER_RESET;
      end
    end else if (wr_filter) begin
      filter_entry_word[filter_write_ptr] <= pwdata;
    end
  end

  for (genvar g = 0; g < FILTER_WORDS; g++) begin : g_filter_out
    assign wakeup_frame_filter[g*DATA_W +: DATA_W] = filter_entry_word[g];
  end

  hwk_frame_qual u_qual (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .rx_frame_end               (rx_frame_end),
    .rx_frame_ok                (rx_frame_ok),
    .rx_dest_addr               (rx_dest_addr),
    .rx_magic_seen              (rx_magic_seen),
    .rx_filter_hit              (rx_filter_hit),
    .global_unicast_wake_enable (global_unicast_wake_enable),
    .wake_frame_enable          (wake_frame_enable),
    .magic_packet_enable        (magic_packet_enable),
    .unicast_hit                (unicast_hit),
    .wake_frame_hit             (wake_frame_hit),
    .magic_hit                  (magic_hit)
  );

  // Wake only while asleep; awake traffic just updates the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= power_save
                    & (unicast_hit | wake_frame_hit | magic_hit);
    end
  end

  a_unicast_wakes: assert property (
    power_save && unicast_hit |=> wake_event)
    else $error("global unicast did not wake");

  a_unicast_da: assert property (
    unicast_hit |-> $past(rx_dest_addr[DA_GROUP_BIT]) == 1'b0
                    && $past(rx_frame_end) && $past(rx_frame_ok))
    else $error("unicast hit on group address");

  a_unicast_gated: assert property (
    $rose(rx_frame_end) && !global_unicast_wake_enable |=> !unicast_hit)
    else $error("unicast hit while disabled");

  a_wake_frame_received_sets: assert property (
    wake_frame_hit && !local_reset |=> wake_frame_received)
    else $error("wake frame flag not set");

  a_wake_frame_received_holds: assert property (
    wake_frame_received && !clr_wake_frame_received && !local_reset
    |=> wake_frame_received)
    else $error("wake frame flag lost");

  a_mpr_sets: assert property (
    magic_hit && !local_reset |=> magic_packet_received)
    else $error("magic flag not set");

  a_mpr_clears: assert property (
    clr_mpr && !magic_hit && !local_reset |=> !magic_packet_received)
    else $error("magic flag not cleared");

  a_wuf_disabled: assert property (
    !wake_frame_enable |=> !wake_frame_hit)
    else $error("wake frame hit while disabled");

  a_magic_disabled: assert property (
    !magic_packet_enable |=> !magic_hit)
    else $error("magic hit while disabled");

  a_ptr_advance: assert property (
    wr_filter && !local_reset
    |=> filter_write_ptr == $past(filter_write_ptr) + 3'h1)
    else $error("filter pointer did not advance");

  a_ptr_wraps: assert property (
    wr_filter && !local_reset && filter_write_ptr == PTR_LAST
    |=> filter_write_ptr == PTR_FIRST)
    else $error("filter pointer did not wrap");

  a_ptr_reset: assert property (
    local_reset |=> filter_write_ptr == PTR_FIRST)
    else $error("filter pointer not reset");

  a_reserved_zero: assert property (
    pready |-> (prdata & ~CSR_DEFINED) == '0)
    else $error("reserved bits read nonzero");

  a_answer_once: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("answer not one wait state");

  a_err_unmapped: assert property (
    commit && decode(paddr) == HWK_SEL_NONE |-> pslverr)
    else $error("unmapped access without error");

  a_wake_frame_received_clears: assert property (
    clr_wake_frame_received && !wake_frame_hit && !local_reset |=> !wake_frame_received)
    else $error("wake frame flag not cleared");

  a_mpr_holds: assert property (
    magic_packet_received && !clr_mpr && !local_reset
    |=> magic_packet_received)
    else $error("magic flag lost");

  a_enables_reset: assert property (
    local_reset |=> !global_unicast_wake_enable && !wake_frame_enable
                    && !magic_packet_enable)
    else $error("enables survived local reset");

  a_enables_written: assert property (
    wr_csr && !local_reset
    |=> global_unicast_wake_enable == $past(pwdata[BIT_GUE])
        && wake_frame_enable == $past(pwdata[BIT_WAKE_FRAME_ENABLE])
        && magic_packet_enable == $past(pwdata[BIT_MAGIC_PACKET_ENABLE]))
    else $error("enable bits not written");

  a_ptr_holds: assert property (
    !wr_filter && !local_reset |=> $stable(filter_write_ptr))
    else $error("filter pointer moved without write");

  a_filter_lands: assert property (
    wr_filter |=> filter_entry_word[$past(filter_write_ptr)] == $past(pwdata))
    else $error("filter word not written");

  a_wake_needs_sleep: assert property (
    !power_save |=> !wake_event)
    else $error("wake event while awake");
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hwk_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic dig_rst, soft_rst, power_save, wake_event, fe, fok, fm, fh, e;
  logic [DA_W-1:0] fda;
  logic [FILTER_WORDS*DATA_W-1:0] filt;
  logic [PTR_W-1:0] ptr;
  int errors, num_checks, wakes;

  hwk_fabric_model fab (.pclk(pclk), .rx_frame_end(fe), .rx_frame_ok(fok),
    .rx_dest_addr(fda), .rx_magic_seen(fm), .rx_filter_hit(fh));
  hwk_wakeup_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_reset(dig_rst), .soft_reset(soft_rst), .rx_frame_end(fe),
    .rx_frame_ok(fok), .rx_dest_addr(fda), .rx_magic_seen(fm),
    .rx_filter_hit(fh), .power_save(power_save),
    .wakeup_frame_filter(filt), .filter_write_ptr(ptr),
    .wake_event(wake_event));

  always @(posedge pclk) if (wake_event === 1'b1) wakes <= wakes + 1;

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read here are those the edge itself sampled
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin errors++; give_verdict(); end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic csr_is(input logic [31:0] exp);
    apb(1'b0, ADDR_CSR, '0);
    check("csr", rd, exp);
  endtask

  task automatic frame(input logic [47:0] da, input logic m, h,
                       input int dw, input logic [31:0] ec);
    int w0;
    w0 = wakes;
    fab.send(da, 1'b1, m, h);
    repeat (4) @(posedge pclk);
    check("wakes", 32'(wakes - w0), 32'(dw));
    csr_is(ec);
  endtask

  task automatic t_reset_regs;
    @(negedge pclk);
    check("ptr", 32'(ptr), 32'h0);
    check("filter", filt[31:0], 32'h0);
    csr_is(32'h0);
    apb(1'b1, ADDR_CSR, 32'hffff_ffff);
    csr_is(32'h0000_0206);
  endtask

  task automatic t_magic;
    apb(1'b1, ADDR_CSR, 32'h0000_0002);
    frame(48'h1, 1'b1, 1'b0, 1, 32'h0000_0022);
    frame(48'h1, 1'b0, 1'b1, 0, 32'h0000_0022);
    apb(1'b1, ADDR_CSR, 32'h0000_0002);
    csr_is(32'h0000_0022);
    apb(1'b1, ADDR_CSR, 32'h0000_0022);
    csr_is(32'h0000_0002);
    apb(1'b1, ADDR_CSR, 32'h0);
    frame(48'h1, 1'b1, 1'b0, 0, 32'h0);
  endtask

  task automatic t_wake_frame;
    apb(1'b1, ADDR_CSR, 32'h0000_0004);
    frame(48'h1, 1'b0, 1'b1, 1, 32'h0000_0044);
    frame(48'h1, 1'b1, 1'b0, 0, 32'h0000_0044);
    apb(1'b1, ADDR_CSR, 32'h0000_0044);
    csr_is(32'h0000_0004);
  endtask

  task automatic t_unicast;
    apb(1'b1, ADDR_CSR, 32'h0000_0200);
    frame(48'h0000_0000_0301, 1'b0, 1'b0, 0, 32'h0000_0200);
    frame(48'h0000_0000_0300, 1'b0, 1'b0, 1, 32'h0000_0200);
    power_save <= 1'b0;
    frame(48'h0000_0000_0300, 1'b0, 1'b0, 0, 32'h0000_0200);
    power_save <= 1'b1;
    apb(1'b1, ADDR_CSR, 32'h0);
    frame(48'h0000_0000_0300, 1'b0, 1'b0, 0, 32'h0);
  endtask

  task automatic t_filter;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, ADDR_FILTER, 32'h1111_1111 * (i + 1));
      @(negedge pclk);
      check("ptr", 32'(ptr), 32'((i + 1) % 8));
    end
    check("word0", filt[31:0], 32'h9999_9999);
    check("word7", filt[255:224], 32'h8888_8888);
    apb(1'b1, ADDR_CSR, 32'h0000_0206);
    @(posedge pclk) soft_rst <= 1'b1;
    @(posedge pclk) soft_rst <= 1'b0;
    @(negedge pclk);
    check("ptr", 32'(ptr), 32'h0);
    csr_is(32'h0);
    apb(1'b1, ADDR_FILTER, 32'h0);
    @(posedge pclk) dig_rst <= 1'b1;
    @(posedge pclk) dig_rst <= 1'b0;
    @(negedge pclk);
    check("ptr", 32'(ptr), 32'h0);
    check("word0", filt[31:0], 32'h0);
    check("word1", filt[63:32], 32'h2222_2222);
  endtask

  task automatic t_unmapped;
    apb(1'b1, ADDR_CSR, 32'h0000_0002);
    apb(1'b1, 8'h40, 32'hffff_ffff);
    check("err", 32'(e), 32'h1);
    csr_is(32'h0000_0002);
    check("err", 32'(e), 32'h0);
    apb(1'b0, 8'h40, '0);
    check("rdata", rd, 32'h0);
    check("err", 32'(e), 32'h1);
    apb(1'b0, ADDR_FILTER, '0);
    check("rdata", rd, 32'h0);
    check("err", 32'(e), 32'h0);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; dig_rst = 1'b0; soft_rst = 1'b0;
    power_save = 1'b1; errors = 0; num_checks = 0; wakes = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_magic();
    t_wake_frame();
    t_unicast();
    t_filter();
    t_unmapped();
    give_verdict();
  end
endmodule
`default_nettype wire
